// ==== design/qbp_p2_pin.v ====
`timescale 1ns/1ps
// ----------------------------------------
// push-pull port-2 pin cell
// ----------------------------------------
module qbp_p2_pin (
  dir_in,
  latch,
  pin_in,
  pin_out,
  pin_oe,
  pull_up,
  rd_val
);
  input wire dir_in;
  input wire latch;
  input wire pin_in;
  output wire pin_out;
  output wire pin_oe;
  output wire pull_up;
  output wire rd_val;
  assign pin_out = latch;
  assign pin_oe = ~dir_in;
  assign pull_up = dir_in;
  assign rd_val = dir_in ? pin_in : latch;
endmodule

// ==== design/qbp_ports.v ====
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "qbp_map.vh"
module qbp_ports (
  clk,
  reset,
  addr,
  wdata,
  wr,
  rd,
  rdata,
  p0_in,
  p0_out,
  p0_oe,
  p0_pull,
  p1_in,
  p1_out,
  p1_oe,
  p1_pull,
  p2_in,
  p2_out,
  p2_oe,
  p2_pull,
  p3_in,
  p3_out,
  p3_oe,
  pwm_in,
  vsync_in,
  hsync_in,
  half_out_in,
  half_in_out,
  sda_drive_low,
  scl_drive_low,
  sda_level,
  scl_level,
  conv_pin,
  conv_enable,
  ext_irq_src
);
  // register bus
  input wire clk;
  input wire reset;
  input wire [4:0] addr;
  input wire [7:0] wdata;
  input wire wr;
  input wire rd;
  output reg [7:0] rdata;

  // port 0 pins
  input wire [7:0] p0_in;
  output reg [7:0] p0_out;
  output reg [7:0] p0_oe;
  output reg [7:0] p0_pull;

  // port 1 pins, pin 6 is input only
  input wire [6:0] p1_in;
  output reg [5:0] p1_out;
  output reg [5:0] p1_oe;
  output reg [6:0] p1_pull;

  // port 2 pins, push-pull with direction
  input wire [7:0] p2_in;
  output reg [7:0] p2_out;
  output reg [7:0] p2_oe;
  output reg [7:0] p2_pull;

  // port 3 pins, open drain
  input wire [1:0] p3_in;
  output reg [1:0] p3_out;
  output reg [1:0] p3_oe;

  // alternate-function units
  input wire [5:0] pwm_in;
  input wire vsync_in;
  input wire hsync_in;
  input wire half_out_in;
  output reg half_in_out;
  input wire sda_drive_low;
  input wire scl_drive_low;
  output reg sda_level;
  output reg scl_level;
  output reg [1:0] conv_pin;
  output reg conv_enable;
  output reg ext_irq_src;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] port0_q;
  // ports 1 and 3 keep only the bits that have pins; port 1 bit 6 drives nothing
  reg [6:0] port1_q;
  reg [7:0] p2dir_q;
  reg [7:0] port2_q;
  reg [1:0] port3_q;
  reg [7:0] sync_q;
  reg [7:0] analog_q;
  reg [7:0] irqen_q;
  reg [7:0] sbsts_q;

  function hit;
    input [4:0] a;
    input [4:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      port0_q <= `QBP_RST_PORT0;
      port1_q <= `QBP_RST_P1PIN;
      p2dir_q <= `QBP_RST_P2DIR;
      port2_q <= `QBP_RST_PORT2;
      port3_q <= `QBP_RST_PORT3;
      analog_q <= `QBP_RST_ANALOG;
      sync_q <= `QBP_RST_SYNC;
      irqen_q <= `QBP_RST_IRQEN;
      sbsts_q <= `QBP_RST_SBSTS;
    end else if (wr) begin
      // latches written regardless of pin owner
      if (hit(addr, `QBP_OFF_PORT0)) port0_q <= wdata;
      if (hit(addr, `QBP_OFF_PORT1)) port1_q <= wdata[6:0];
      if (hit(addr, `QBP_OFF_P2DIR)) p2dir_q <= wdata;
      if (hit(addr, `QBP_OFF_PORT2)) port2_q <= wdata;
      if (hit(addr, `QBP_OFF_PORT3)) port3_q <= wdata[1:0];
      if (hit(addr, `QBP_OFF_SYNC)) sync_q <= wdata;
      if (hit(addr, `QBP_OFF_ANALOG)) analog_q <= wdata;
      if (hit(addr, `QBP_OFF_IRQEN)) irqen_q <= wdata;
      if (hit(addr, `QBP_OFF_SBSTS)) sbsts_q <= wdata;
    end
  end

  // ----------------------------------------
  // pin selection
  // ----------------------------------------
  wire vsync_out_sel_n = sync_q[`QBP_SYNC_VSEL];
  wire hsync_out_sel_n = sync_q[`QBP_SYNC_HSEL];
  wire half_freq_sel_n = sync_q[`QBP_SYNC_HALF];
  // either analog bit hands over both pins: the converters share one start
  wire conv_sel = ~analog_q[`QBP_AN_CONV0] | ~analog_q[`QBP_AN_CONV1];
  wire serial_bus_pin_sel_n = sbsts_q[`QBP_SB_SEL];
  wire ext_irq_enable = irqen_q[`QBP_IRQ_EXT];

  wire [7:0] p0_alt_sel;
  wire [7:0] p0_alt_val;
  wire [7:0] p0_oe_d;
  wire [7:0] p0_pull_d;
  wire [7:0] p0_out_d;
  assign p0_alt_sel[5:0] = ~analog_q[5:0];
  assign p0_alt_val[5:0] = pwm_in;
  assign p0_alt_sel[6] = ~vsync_out_sel_n;
  assign p0_alt_sel[7] = ~hsync_out_sel_n;
  assign p0_alt_val[6] = vsync_in;
  assign p0_alt_val[7] = hsync_in;

  // ----------------------------------------
  // port 0 cells
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_p0
      qbp_quasi_pin u_pin (
        .latch(port0_q[i]),
        .alt_sel(p0_alt_sel[i]),
        .alt_val(p0_alt_val[i]),
        .pin_in(p0_in[i]),
        .pin_out(p0_out_d[i]),
        .pin_oe(p0_oe_d[i]),
        .pull_up(p0_pull_d[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // port 1 cells
  // ----------------------------------------
  wire [5:0] p1_alt_sel;
  wire [5:0] p1_alt_val;
  wire [5:0] p1_oe_d;
  wire [5:0] p1_pull_d;
  wire [5:0] p1_out_d;
  assign p1_alt_sel[1:0] = {2{conv_sel}};
  assign p1_alt_val[1:0] = 2'h3;
  assign p1_alt_sel[2] = ~half_freq_sel_n;
  assign p1_alt_val[2] = half_out_in;
  assign p1_alt_sel[3] = ~half_freq_sel_n;
  assign p1_alt_val[3] = 1'b1;
  assign p1_alt_sel[5:4] = 2'h0;
  assign p1_alt_val[5:4] = 2'h0;

  generate
    for (i = 0; i < 6; i = i + 1) begin : g_p1
      qbp_quasi_pin u_pin (
        .latch(port1_q[i]),
        .alt_sel(p1_alt_sel[i]),
        .alt_val(p1_alt_val[i]),
        .pin_in(p1_in[i]),
        .pin_out(p1_out_d[i]),
        .pin_oe(p1_oe_d[i]),
        .pull_up(p1_pull_d[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // port 2 cells
  // ----------------------------------------
  wire [7:0] p2_oe_d;
  wire [7:0] p2_pull_d;
  wire [7:0] p2_out_d;
  wire [7:0] p2_rd;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_p2
      qbp_p2_pin u_pin (
        .dir_in(p2dir_q[i]),
        .latch(port2_q[i]),
        .pin_in(p2_in[i]),
        .pin_out(p2_out_d[i]),
        .pin_oe(p2_oe_d[i]),
        .pull_up(p2_pull_d[i]),
        .rd_val(p2_rd[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // port 3
  // ----------------------------------------
  // the serial unit only pulls low; the board resistor gives the high
  // open-drain port3
  wire [1:0] p3_low;
  assign p3_low = serial_bus_pin_sel_n ? ~port3_q :
    {scl_drive_low, sda_drive_low};

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      p0_out <= `QBP_ZERO8;
      p0_oe <= `QBP_ZERO8;
      p0_pull <= `QBP_RST_PORT0;
      p1_out <= 6'h00;
      p1_oe <= 6'h00;
      p1_pull <= `QBP_RST_P1PIN;
      p2_out <= `QBP_RST_PORT2;
      p2_oe <= `QBP_ZERO8;
      p2_pull <= `QBP_RST_P2DIR;
      p3_out <= 2'h0;
      p3_oe <= 2'h0;
      half_in_out <= 1'b0;
      sda_level <= 1'b1;
      scl_level <= 1'b1;
      conv_pin <= 2'h0;
      conv_enable <= 1'b0;
      ext_irq_src <= 1'b0;
    end else begin
      // one flop on every pin output keeps decode glitches off the board
      p0_out <= p0_out_d;
      p0_oe <= p0_oe_d;
      p0_pull <= p0_pull_d;
      p1_out <= p1_out_d;
      p1_oe <= p1_oe_d;
      // input-only pin keeps a pull-up, never drives
      p1_pull <= {1'b1, p1_pull_d};
      p2_out <= p2_out_d;
      p2_oe <= p2_oe_d;
      p2_pull <= p2_pull_d;
      p3_out <= 2'h0;
      p3_oe <= p3_low;
      half_in_out <= half_freq_sel_n ? 1'b0 : p1_in[3];
      sda_level <= p3_in[0];
      scl_level <= p3_in[1];
      conv_enable <= conv_sel;
      conv_pin <= conv_sel ? p1_in[1:0] : 2'h0;
      // only the level goes out; edge detection sits in the interrupt unit
      // external interrupt source gated
      ext_irq_src <= ext_irq_enable & p1_in[6];
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // ports 0, 1 and 3 read live pins; write-only registers read zero
  reg [7:0] rdata_d;

  always @* begin
    rdata_d = `QBP_ZERO8;
    if (rd) begin
      case (addr)
        `QBP_OFF_PORT0: rdata_d = p0_in;
        `QBP_OFF_PORT1: rdata_d = {1'b0, p1_in};
        `QBP_OFF_PORT2: rdata_d = p2_rd;
        `QBP_OFF_PORT3: rdata_d = {6'h00, p3_in};
        `QBP_OFF_SBSTS: rdata_d = sbsts_q;
        default: rdata_d = `QBP_ZERO8;
      endcase
    end
  end

  // rdata stands for one cycle only, so an idle bus reads zero
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= `QBP_ZERO8;
    end else begin
      rdata <= rdata_d;
    end
  end
endmodule

// ==== design/qbp_quasi_pin.v ====
`timescale 1ns/1ps
// ----------------------------------------
// quasi-bidirectional / open-drain pin cell
// ----------------------------------------
module qbp_quasi_pin (
  latch,
  alt_sel,
  alt_val,
  pin_in,
  pin_out,
  pin_oe,
  pull_up
);
  input wire latch;
  input wire alt_sel;
  input wire alt_val;
  input wire pin_in;
  output wire pin_out;
  output wire pin_oe;
  output wire pull_up;
  wire level;
  // latch is kept but ignored while the alternate function owns the pin
  assign level = alt_sel ? alt_val : latch;
  // a one is only a weak pull-up, so the far side may pull the pin low
  assign pin_out = 1'b0;
  assign pin_oe = ~level;
  assign pull_up = level;
endmodule

// ==== inc/qbp_map.vh ====
`ifndef QBP_MAP_VH
`define QBP_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define QBP_OFF_PORT0 5'h00
`define QBP_OFF_PORT1 5'h01
`define QBP_OFF_P2DIR 5'h02
`define QBP_OFF_PORT2 5'h03
`define QBP_OFF_PORT3 5'h04
`define QBP_OFF_SYNC 5'h0B
`define QBP_OFF_ANALOG 5'h0C
`define QBP_OFF_IRQEN 5'h0F
`define QBP_OFF_SBSTS 5'h15
// ----------------------------------------
// reset values
// ----------------------------------------
`define QBP_RST_PORT0 8'hFF
`define QBP_RST_PORT1 8'h7F
`define QBP_RST_P1PIN 7'h7F
`define QBP_RST_P2DIR 8'hFF
`define QBP_RST_PORT2 8'hFF
`define QBP_RST_PORT3 2'h3
`define QBP_RST_SYNC 8'hFF
`define QBP_RST_ANALOG 8'hFF
`define QBP_RST_IRQEN 8'h00
`define QBP_RST_SBSTS 8'h0F
// ----------------------------------------
// field positions
// ----------------------------------------
`define QBP_SYNC_VSEL 0
`define QBP_SYNC_HSEL 1
`define QBP_SYNC_HALF 6
`define QBP_AN_CONV0 6
`define QBP_AN_CONV1 7
`define QBP_IRQ_EXT 1
`define QBP_SB_SEL 3
`define QBP_ZERO8 8'h00
`endif

// ==== sim/qbp_board.sv ====
`timescale 1ns/1ps
// ----
// board wiring; ext masks pull pins low
// ----
module qbp_board (
  input wire [7:0] p0_oe,
  input wire [5:0] p1_oe,
  input wire [7:0] p2_out,
  input wire [7:0] p2_oe,
  input wire [1:0] p3_oe,
  input wire [7:0] ext0,
  input wire [6:0] ext1,
  input wire [7:0] ext2,
  input wire [1:0] ext3,
  output wire [7:0] p0_in,
  output wire [6:0] p1_in,
  output wire [7:0] p2_in,
  output wire [1:0] p3_in
);
  assign p0_in = ~(p0_oe | ext0);
  assign p1_in = {~ext1[6], ~(p1_oe | ext1[5:0])};
  assign p2_in = (p2_oe & p2_out) | (~p2_oe & ~ext2);
  assign p3_in = ~(p3_oe | ext3);
endmodule

// ==== sim/qbp_ports_assertions.sv ====
`timescale 1ns/1ps
// ----
// port block checker
// ----
module qbp_ports_assertions (
  input wire clk,
  input wire reset,
  input wire [4:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire [7:0] p0_out,
  input wire [7:0] p0_oe,
  input wire [7:0] p0_pull,
  input wire [6:0] p1_in,
  input wire [5:0] p1_oe,
  input wire [6:0] p1_pull,
  input wire [7:0] p2_in,
  input wire [7:0] p2_out,
  input wire [7:0] p2_oe,
  input wire [7:0] p2_pull,
  input wire [1:0] p3_out,
  input wire conv_enable,
  input wire ext_irq_src
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  a_rst_pins_high: assert property (
    $fell(reset) |-> p0_pull == 8'hFF && p1_pull == 7'h7F)
    else $error("pull-ups wrong after reset");
  a_p0_no_fight: assert property (
    (p0_oe & p0_pull) == 8'h00 && p0_out == 8'h00)
    else $error("port0 drives high or fights pull-up");
  a_conv_undriven: assert property (
    conv_enable |-> p1_oe[1:0] == 2'h0)
    else $error("converter pin still driven");
  a_p2_dir_pair: assert property (p2_oe == ~p2_pull)
    else $error("port2 pull and drive not exclusive");
  a_p2_drive: assert property (
    wr && addr == 5'h03 ##1 !(wr && addr == 5'h03) |=>
    (p2_out & p2_oe) == ($past(wdata, 2) & p2_oe))
    else $error("port2 output not the latched data");
  a_p2_read: assert property (
    rd && addr == 5'h03 && !$past(wr) |=>
    rdata == (($past(p2_in) & $past(p2_pull)) |
              ($past(p2_out) & ~$past(p2_pull))))
    else $error("port2 read wrong");
  a_dir_wonly: assert property (
    rd && addr == 5'h02 |=> rdata == 8'h00)
    else $error("direction register readable");
  a_p3_open: assert property (p3_out == 2'h0)
    else $error("port3 drives high");
  a_irq_cause: assert property (
    ext_irq_src |-> $past(p1_in[6]) || $past(p1_in[6], 2))
    else $error("interrupt source without pin high");
endmodule
bind qbp_ports qbp_ports_assertions chk_i (.*);

// ==== sim/tb_qbp_ports.sv ====
`timescale 1ns/1ps
module tb_qbp_ports;
  logic clk = 0, reset = 1, wr = 0, rd = 0;
  logic [4:0] addr = 0;
  logic [7:0] wdata = 0, rdata, p0_in, p0_out, p0_oe, p0_pull;
  logic [7:0] p2_in, p2_out, p2_oe, p2_pull, ext0 = 0, ext2 = 0;
  logic [6:0] p1_in, p1_pull, ext1 = 0;
  logic [5:0] p1_out, p1_oe, pwm_in = 0;
  logic [1:0] p3_in, p3_out, p3_oe, conv_pin, ext3 = 0;
  logic vsync_in = 0, hsync_in = 0, half_out_in = 0;
  logic sda_drive_low = 0, scl_drive_low = 0;
  logic half_in_out, sda_level, scl_level, conv_enable, ext_irq_src;
  int fail_count = 0, n_tests = 0;
  qbp_ports DUT (.*);
  qbp_board brd (.*);
  always #50 clk = ~clk;
  // ----
  // helpers
  // ----
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pins settle one edge after the write is taken
  task wreg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
    repeat (3) @(posedge clk);
  endtask
  task rchk(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    // rdata stands only until the next edge: look mid-cycle
    @(negedge clk);
    chk(rdata, e);
    @(posedge clk);
  endtask
  task final_report;
    $display("tests=%0d fails=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task t_reset;
    chk(p2_pull, 8'hFF);
    rchk(5'h00, 8'hFF);
    rchk(5'h01, 8'h7F);
    rchk(5'h03, 8'hFF);
    rchk(5'h04, 8'h03);
    rchk(5'h02, 8'h00);
    rchk(5'h15, 8'h0F);
    rchk(5'h09, 8'h00);
  endtask
  task t_port0;
    wreg(5'h00, 8'h5A);
    chk(p0_oe, 8'hA5);
    ext0 <= 8'h02;
    rchk(5'h00, 8'h58);
    ext0 <= 8'h00;
    pwm_in <= 6'h15;
    hsync_in <= 1;
    wreg(5'h0C, 8'hC0);
    rchk(5'h00, 8'h55);
    wreg(5'h0B, 8'hFC);
    rchk(5'h00, 8'h95);
    wreg(5'h0C, 8'hFF);
    wreg(5'h0B, 8'hFF);
    rchk(5'h00, 8'h5A);
  endtask
  task t_port1;
    wreg(5'h01, 8'h00);
    chk({2'h0, p1_oe}, 8'h3F);
    chk({2'h0, p1_out}, 8'h00);
    chk({1'b0, p1_pull}, 8'h40);
    wreg(5'h01, 8'hFF);
    ext1 <= 7'h01;
    wreg(5'h0C, 8'hBF);
    chk({conv_enable, 5'h00, conv_pin}, 8'h82);
    wreg(5'h0C, 8'h7F);
    chk({7'h00, conv_enable}, 8'h01);
    ext1 <= 7'h00;
    wreg(5'h0C, 8'hFF);
    wreg(5'h0B, 8'hBF);
    rchk(5'h01, 8'h7B);
    chk({7'h00, half_in_out}, 8'h01);
    wreg(5'h0B, 8'hFF);
    chk({7'h00, ext_irq_src}, 8'h00);
    wreg(5'h0F, 8'h02);
    chk({7'h00, ext_irq_src}, 8'h01);
    ext1 <= 7'h40;
    repeat (4) @(posedge clk);
    chk({7'h00, ext_irq_src}, 8'h00);
    ext1 <= 7'h00;
  endtask
  task t_port2;
    wreg(5'h03, 8'h5A);
    wreg(5'h02, 8'h0F);
    chk(p2_pull, 8'h0F);
    chk(p2_oe, 8'hF0);
    chk(p2_out & p2_oe, 8'h50);
    ext2 <= 8'h33;
    rchk(5'h03, 8'h5C);
    ext2 <= 8'h00;
  endtask
  task t_port3;
    wreg(5'h04, 8'h02);
    chk({6'h00, p3_oe}, 8'h01);
    rchk(5'h04, 8'h02);
    wreg(5'h04, 8'h03);
    wreg(5'h15, 8'h07);
    scl_drive_low <= 1;
    ext3 <= 2'h1;
    repeat (4) @(posedge clk);
    chk({6'h00, p3_oe}, 8'h02);
    chk({6'h00, scl_level, sda_level}, 8'h00);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    t_reset;
    t_port0;
    t_port1;
    t_port2;
    t_port3;
    final_report;
  end
  // whole run is about 160 cycles
  initial begin
    #200000;
    fail_count++;
    final_report;
  end
endmodule
